/* File: logic/sids_defs.svh */
// constants for the station identification scheduler
`ifndef SIDS_DEFS_SVH
`define SIDS_DEFS_SVH
`define SIDS_CLK_HZ 64'd200000000
`define SIDS_HOLDOFF_S 64'd120
`define SIDS_HOLDOFF_CYC (`SIDS_HOLDOFF_S * `SIDS_CLK_HZ)
`define SIDS_UNIT_S 64'd60
`define SIDS_UNIT_CYC (`SIDS_UNIT_S * `SIDS_CLK_HZ)
`define SIDS_INT_OFF 8'hff
`define SIDS_ADDR_CTRL 12'h000
`define SIDS_ADDR_EXCL 12'h004
`define SIDS_ADDR_MIX 12'h008
`define SIDS_ADDR_STAT 12'h00c
`define SIDS_MODE_ANALOG 2'h0
`define SIDS_MODE_DIGITAL 2'h1
`define SIDS_MODE_DYNAMIC 2'h2
`define SIDS_INT_RST 8'hff
`endif

/* File: logic/sids_pkg.sv */
// types for the station identification scheduler
package sids_pkg;
   typedef enum logic [1:0] {
      SIDS_IDLE,
      SIDS_EXCL,
      SIDS_MIX
   } sids_state_t;
endpackage

/* File: logic/sids_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sids_sync (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // data
   input wire logic i_d,
   output logic o_q
);
   logic meta_q;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= 1'b0;
         o_q <= 1'b0;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule

/* File: logic/sids_timer.sv */
// interval timer counting minute ticks; 255 means disabled
`timescale 1ns/10ps
`include "sids_defs.svh"
module sids_timer (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // control
   input wire logic i_tick,
   input wire logic i_restart,
   input wire logic [7:0] i_interval,
   // status
   output logic o_expired
);
   logic [7:0] cnt_q;
   wire off = (i_interval == `SIDS_INT_OFF);
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= 8'h00;
         o_expired <= 1'b0;
      end else if (i_restart || off) begin
         cnt_q <= 8'h00;
         o_expired <= 1'b0;
      end else if (i_tick && !o_expired) begin
         cnt_q <= cnt_q + 8'h01;
         o_expired <= (cnt_q + 8'h01) >= i_interval;
      end
   end
endmodule

/* File: logic/sids_sched.sv */
// station identification scheduler with apb registers
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`include "sids_defs.svh"
module sids_sched
   import sids_pkg::*;
#(
   parameter longint HOLDOFF_CYC = `SIDS_HOLDOFF_CYC,
   parameter longint UNIT_CYC = `SIDS_UNIT_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // repeater keying and receive activity pins
   input wire logic i_tx_keyed,
   input wire logic i_tot_dekey,
   input wire logic i_rx_active,
   input wire logic i_acc_ptt,
   // tone generator handshake
   input wire logic i_tag_done,
   output logic o_tag_start,
   output logic o_tag_mixed,
   output logic o_tag_busy,
   output logic o_tag_abort
);
   import sids_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   logic keyed_s, tot_s, rx_s, ptt_s;
   logic [3:0] pin_raw, pin_syn;
   assign pin_raw = {i_tx_keyed, i_tot_dekey, i_rx_active, i_acc_ptt};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         sids_sync u_sync (
            .i_mclk(i_mclk),
            .i_rst_b(i_rst_b),
            .i_d(pin_raw[gi]),
            .o_q(pin_syn[gi])
         );
      end
   endgenerate
   assign keyed_s = pin_syn[3];
   assign tot_s = pin_syn[2];
   assign rx_s = pin_syn[1];
   assign ptt_s = pin_syn[0];

   // ****************************************
   // registers
   // ****************************************
   logic [1:0] mode_q;
   logic [7:0] excl_int_q, mix_int_q;
   logic keyed_q, tot_q;
   logic excl_pend_q, mix_pend_q;
   logic [35:0] hold_q;
   logic hold_done_q;
   logic [35:0] unit_q;
   logic tick_q;
   logic [7:0] tag_cnt_q;
   logic [7:0] abort_cnt_q;
   sids_state_t state_q;

   // ****************************************
   // apb decode
   // ****************************************
   wire acc = i_psel && i_penable;
   wire wr = acc && i_pwrite;
   wire sel_ctrl = (i_paddr == `SIDS_ADDR_CTRL);
   wire sel_excl = (i_paddr == `SIDS_ADDR_EXCL);
   wire sel_mix = (i_paddr == `SIDS_ADDR_MIX);
   wire sel_stat = (i_paddr == `SIDS_ADDR_STAT);
   wire mapped = sel_ctrl | sel_excl | sel_mix | sel_stat;
   wire [31:0] stat_word = {8'h00, abort_cnt_q, tag_cnt_q, 1'b0,
      hold_done_q, excl_pend_q, mix_pend_q, keyed_q,
      (state_q == SIDS_MIX), (state_q == SIDS_EXCL),
      (state_q != SIDS_IDLE)};
   wire [31:0] rd_word = sel_ctrl ? {30'h0, mode_q} :
      sel_excl ? {24'h0, excl_int_q} :
      sel_mix ? {24'h0, mix_int_q} :
      sel_stat ? stat_word : 32'h0;

   // one-wait answer, registered one cycle into the access phase
   wire ans_d = acc && !o_pready;
   wire [31:0] prdata_d = ans_d ? rd_word : 32'h0;
   wire pslverr_d = ans_d && !mapped;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= ans_d;
      end
   end

   // read data stands only with pready, zero otherwise
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_prdata <= 32'h0;
      end else begin
         o_prdata <= prdata_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= pslverr_d;
      end
   end

   // unmapped writes miss every select and change nothing
   wire wr_take = wr && o_pready;
   wire wr_ctrl = wr_take && sel_ctrl;
   wire wr_excl = wr_take && sel_excl;
   wire wr_mix = wr_take && sel_mix;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_q <= `SIDS_MODE_ANALOG;
      end else if (wr_ctrl) begin
         mode_q <= i_pwdata[1:0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         excl_int_q <= `SIDS_INT_RST;
      end else if (wr_excl) begin
         excl_int_q <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mix_int_q <= `SIDS_INT_RST;
      end else if (wr_mix) begin
         mix_int_q <= i_pwdata[7:0];
      end
   end

   // ****************************************
   // keying edges and hold-off
   // ****************************************
   wire analog = (mode_q == `SIDS_MODE_ANALOG);
   wire key_up = keyed_s && !keyed_q;
   wire de_key = !keyed_s && keyed_q;
   wire tot_edge = tot_s && !tot_q;
   wire all_off = (excl_int_q == `SIDS_INT_OFF) &&
      (mix_int_q == `SIDS_INT_OFF);

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         keyed_q <= 1'b0;
         tot_q <= 1'b0;
      end else begin
         keyed_q <= keyed_s;
         tot_q <= tot_s;
      end
   end

   // hold-off restarts on every key-up; a de-key clears it
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hold_q <= 36'h0;
         hold_done_q <= 1'b0;
      end else if (key_up || !keyed_s) begin
         hold_q <= 36'h0;
         hold_done_q <= 1'b0;
      end else if (!hold_done_q) begin
         hold_q <= hold_q + 36'h1;
         hold_done_q <= (hold_q + 36'h1) >= HOLDOFF_CYC[35:0];
      end
   end

   // ****************************************
   // interval timers, minute ticks
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         unit_q <= 36'h0;
         tick_q <= 1'b0;
      end else if (unit_q >= UNIT_CYC[35:0] - 36'h1) begin
         unit_q <= 36'h0;
         tick_q <= 1'b1;
      end else begin
         unit_q <= unit_q + 36'h1;
         tick_q <= 1'b0;
      end
   end

   wire tag_fin = (state_q != SIDS_IDLE) && i_tag_done;
   logic excl_exp, mix_exp;
   sids_timer u_excl (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_tick(tick_q),
      .i_restart(tag_fin),
      .i_interval(excl_int_q),
      .o_expired(excl_exp)
   );
   sids_timer u_mix (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_tick(tick_q),
      .i_restart(tag_fin),
      .i_interval(mix_int_q),
      .o_expired(mix_exp)
   );

   // ****************************************
   // scheduling
   // ****************************************
   // analog only; digital and dynamic modes never abort
   wire abort_now = (state_q == SIDS_EXCL) && analog &&
      (rx_s || keyed_s);
   // a time-out de-key sends a tag even before the timer ran out
   wire excl_go = (state_q == SIDS_IDLE) && !all_off &&
      ((excl_pend_q && de_key) || tot_edge);
   wire mix_go = (state_q == SIDS_IDLE) && mix_pend_q && !excl_go &&
      analog && keyed_s && hold_done_q && !all_off;
   // expiry lingers in the completion cycle; masked so it cannot re-arm
   wire excl_set = ((excl_exp && !tag_fin) || tot_edge) &&
      !all_off;
   wire mix_set = mix_exp && !tag_fin && !all_off;

   // set wins over completion clear
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         excl_pend_q <= 1'b0;
      end else begin
         excl_pend_q <= excl_set || (excl_pend_q && !tag_fin);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mix_pend_q <= 1'b0;
      end else begin
         mix_pend_q <= mix_set || (mix_pend_q && !tag_fin);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= SIDS_IDLE;
      end else begin
         case (state_q)
            SIDS_IDLE: begin
               if (excl_go) state_q <= SIDS_EXCL;
               else if (mix_go) state_q <= SIDS_MIX;
            end
            SIDS_EXCL: begin
               if (i_tag_done || abort_now) state_q <= SIDS_IDLE;
            end
            SIDS_MIX: begin
               if (i_tag_done || !keyed_s) state_q <= SIDS_IDLE;
            end
            default: state_q <= SIDS_IDLE;
         endcase
      end
   end

   // ****************************************
   // outputs and counters
   // ****************************************
   wire start_d = excl_go || mix_go;
   wire mixed_d = (state_q == SIDS_MIX) || mix_go;
   // busy drops with done or abort, so a late done is never honoured
   wire busy_d = start_d ||
      ((state_q != SIDS_IDLE) && !i_tag_done && !abort_now);
   wire abort_d = abort_now && !i_tag_done;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tag_start <= 1'b0;
      end else begin
         o_tag_start <= start_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tag_mixed <= 1'b0;
      end else begin
         o_tag_mixed <= mixed_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tag_busy <= 1'b0;
      end else begin
         o_tag_busy <= busy_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tag_abort <= 1'b0;
      end else begin
         o_tag_abort <= abort_d;
      end
   end

   // counters wrap at 255; software takes differences between reads
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tag_cnt_q <= 8'h00;
      end else if (tag_fin) begin
         tag_cnt_q <= tag_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         abort_cnt_q <= 8'h00;
      end else if (abort_d) begin
         abort_cnt_q <= abort_cnt_q + 8'h01;
      end
   end
   // ptt on the accessory port never cancels an exclusive tag
   wire unused_ptt = ptt_s;
endmodule

/* File: tb/sids_sched_asserts.sv */
// port checker for the identification scheduler
`timescale 1ns/10ps
module sids_sched_asserts #(
   parameter longint HOLDOFF_CYC = 200
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // watched ports
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic i_tx_keyed,
   input wire logic i_tot_dekey,
   input wire logic i_rx_active,
   input wire logic i_tag_done,
   input wire logic o_tag_start,
   input wire logic o_tag_mixed,
   input wire logic o_tag_busy,
   input wire logic o_tag_abort
);
   // ****
   // helper state
   // ****
   logic [1:0] mode_q;
   longint keyed_q;
   logic [7:0] gap_q;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) mode_q <= 2'h0;
      else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h0)
         mode_q <= i_pwdata[1:0];
   end
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) keyed_q <= 0;
      else keyed_q <= i_tx_keyed ? keyed_q + 1 : 0;
   end
   // cycles since the last de-key; saturates so idle never matches
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) gap_q <= 8'hff;
      else if (i_tot_dekey || $fell(i_tx_keyed)) gap_q <= 8'h00;
      else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   sequence excl_start;
      o_tag_start && !o_tag_mixed;
   endsequence
   sequence mix_start;
      o_tag_start && o_tag_mixed;
   endsequence
   a_excl_at_dekey: assert property (
      excl_start |-> gap_q <= 8'h08 && !i_tx_keyed)
      else $error("exclusive tag started away from a de-key");
   a_start_busy: assert property (
      o_tag_start |-> o_tag_busy ##1 !o_tag_start)
      else $error("tag start without busy or longer than one cycle");
   a_mix_holdoff: assert property (
      mix_start |-> keyed_q >= HOLDOFF_CYC)
      else $error("mixed tag inside the key-up hold-off");
   a_mix_analog: assert property (mix_start |-> mode_q == 2'h0)
      else $error("mixed tag outside analog mode");
   a_abort_analog: assert property (
      o_tag_busy && !o_tag_mixed && mode_q == 2'h0 && i_rx_active
      |-> ##[1:6] (o_tag_abort || !o_tag_busy))
      else $error("exclusive tag not aborted by receive activity");
   a_abort_digital: assert property (o_tag_abort |-> mode_q == 2'h0)
      else $error("abort outside analog mode");
   a_done_ends: assert property (i_tag_done && o_tag_busy |=> !o_tag_busy)
      else $error("busy held after tag done");
   a_busy_holds: assert property (
      o_tag_busy && !o_tag_mixed && mode_q != 2'h0 && !i_tag_done
      |=> o_tag_busy)
      else $error("digital exclusive tag ended early");
endmodule

/* File: tb/sids_tone_model.sv */
// tone generator model answering tag starts with a done pulse
`timescale 1ns/10ps
module sids_tone_model (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // control
   input wire logic i_slow,
   input wire logic i_tag_start,
   input wire logic i_tag_busy,
   output logic o_tag_done
);
   // ****
   // countdown
   // ****
   int cnt_q;
   // done only while busy, so an aborted tag never sees one
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= 0;
         o_tag_done <= 1'b0;
      end else begin
         o_tag_done <= i_tag_busy && cnt_q == 1;
         if (i_tag_start) cnt_q <= i_slow ? 60 : 6;
         else if (cnt_q != 0) cnt_q <= cnt_q - 1;
      end
   end
endmodule

/* File: tb/test_sids_sched.sv */
// self-checking bench for the identification scheduler
`timescale 1ns/10ps
`include "sids_defs.svh"
module test_sids_sched;
   logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic tx_keyed, tot_dekey, rx_active, acc_ptt;
   logic tag_done, tag_start, tag_mixed, tag_busy, tag_abort;
   int err_total = 0, comparisons = 0, starts = 0, aborts = 0, k;
   sids_sched #(.HOLDOFF_CYC(200), .UNIT_CYC(20)) sids_sched_i (
      .i_mclk(mclk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_tx_keyed(tx_keyed), .i_tot_dekey(tot_dekey),
      .i_rx_active(rx_active), .i_acc_ptt(acc_ptt), .i_tag_done(tag_done),
      .o_tag_start(tag_start), .o_tag_mixed(tag_mixed),
      .o_tag_busy(tag_busy), .o_tag_abort(tag_abort));
   sids_tone_model sids_tone_model_i (.i_mclk(mclk), .i_rst_b(rst_b),
      .i_slow(slow), .i_tag_start(tag_start), .i_tag_busy(tag_busy),
      .o_tag_done(tag_done));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (tag_start === 1'b1) starts++;
      if (tag_abort === 1'b1) aborts++;
   end
   // ****
   // tasks
   // ****
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) chk("pready", 32'h1, 32'h0);
      if (n == 20) print_verdict();
      // idle edge: a following call never re-drives psel in this step
      @(posedge mclk);
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] x, logic [31:0] m, logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk("prdata", x, q & m);
      chk("pslverr", 32'(xe), 32'(e));
   endtask
   task automatic key(int n);
      tx_keyed <= 1'b1;
      cyc(n);
      tx_keyed <= 1'b0;
   endtask
   task automatic wait_tag(logic mix, logic st);
      k = 0;
      while ((st ? tag_start : tag_busy) !== st && k < 400) begin
         @(posedge mclk);
         k++;
      end
      if (st) chk("tag_mixed", 32'(mix), 32'(tag_mixed));
      if (k == 400) chk("wait", 32'h0, 32'h1);
      if (k == 400) print_verdict();
   endtask
   // ****
   // scenarios
   // ****
   initial begin
      {psel, penable, pwrite, tx_keyed, tot_dekey, rx_active} <= 6'h0;
      {acc_ptt, slow, rst_b, paddr, pwdata} <= '0;
      cyc(6);
      rst_b <= 1'b1;
      cyc(2);
      rd(`SIDS_ADDR_CTRL, 32'h0, 32'hffffffff, 1'b0);
      rd(`SIDS_ADDR_EXCL, 32'hff, 32'hffffffff, 1'b0);
      rd(`SIDS_ADDR_MIX, 32'hff, 32'hffffffff, 1'b0);
      rd(12'h010, 32'h0, 32'hffffffff, 1'b1);
      key(300);
      cyc(40);
      chk("starts", 32'h0, starts);
      wr(`SIDS_ADDR_EXCL, 32'h2);
      wr(`SIDS_ADDR_MIX, 32'h2);
      cyc(80);
      chk("starts", 32'h0, starts);
      key(20);
      wait_tag(1'b0, 1'b1);
      cyc(12);
      rd(`SIDS_ADDR_STAT, 32'h100, 32'hff31, 1'b0);
      key(5);
      cyc(15);
      chk("starts", 32'h1, starts);
      slow <= 1'b1;
      cyc(40);
      key(10);
      wait_tag(1'b0, 1'b1);
      rx_active <= 1'b1;
      cyc(8);
      chk("aborts", 32'h1, aborts);
      rx_active <= 1'b0;
      key(10);
      wait_tag(1'b0, 1'b1);
      wait_tag(1'b0, 1'b0);
      for (int m = 1; m < 3; m++) begin
         wr(`SIDS_ADDR_CTRL, 32'(m));
         cyc(50);
         key(10);
         wait_tag(1'b0, 1'b1);
         rx_active <= 1'b1;
         acc_ptt <= 1'b1;
         cyc(20);
         chk("busy", 32'h1, 32'(tag_busy));
         rx_active <= 1'b0;
         acc_ptt <= 1'b0;
         wait_tag(1'b0, 1'b0);
      end
      chk("aborts", 32'h1, aborts);
      wr(`SIDS_ADDR_CTRL, 32'h0);
      wr(`SIDS_ADDR_EXCL, 32'h20);
      slow <= 1'b0;
      key(30);
      tot_dekey <= 1'b1;
      wait_tag(1'b0, 1'b1);
      tot_dekey <= 1'b0;
      wait_tag(1'b0, 1'b0);
      key(150);
      cyc(5);
      chk("starts", 32'h6, starts);
      tx_keyed <= 1'b1;
      wait_tag(1'b1, 1'b1);
      chk("holdoff", 32'h1, 32'(k >= 200 && k <= 215));
      wait_tag(1'b0, 1'b0);
      tx_keyed <= 1'b0;
      wr(`SIDS_ADDR_CTRL, 32'h1);
      key(300);
      cyc(2);
      chk("starts", 32'h7, starts);
      rd(`SIDS_ADDR_STAT, 32'h10600, 32'hffff01, 1'b0);
      print_verdict();
   end
endmodule
bind sids_sched sids_sched_asserts #(.HOLDOFF_CYC(HOLDOFF_CYC))
   sids_sched_asserts_i (.i_mclk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_pready, .i_tx_keyed, .i_tot_dekey, .i_rx_active,
   .i_tag_done, .o_tag_start, .o_tag_mixed, .o_tag_busy, .o_tag_abort);
